/* design/wfr_pkg.sv */
package wfr_pkg;

	// Core clock and watchdog time units
	localparam int unsigned CLK_HZ         = 20_000_000;
	localparam int unsigned SHORT_TICK_MS  = 150;
	localparam int unsigned LONG_TICK_MS   = 2500;
	localparam int unsigned SHORT_TICK_CYC = (CLK_HZ / 1000) * SHORT_TICK_MS;
	localparam int unsigned LONG_TICK_CYC  = (CLK_HZ / 1000) * LONG_TICK_MS;
	localparam int unsigned TICK_CNT_W     = 26;

	// Width of the reset pulse, in core cycles
	localparam logic [4:0]  RST_PULSE_CYC  = 5'h10;

	// Divider offset in the frequency equation
	localparam logic [8:0]  DIV_OFFSET     = 9'h003;

	// Register offsets
	localparam logic [3:0]  OFF_CTRL       = 4'h0;
	localparam logic [3:0]  OFF_SEL        = 4'h1;
	localparam logic [3:0]  OFF_PROG_N     = 4'h2;
	localparam logic [3:0]  OFF_PROG_M     = 4'h3;
	localparam logic [3:0]  OFF_REC_N      = 4'h4;
	localparam logic [3:0]  OFF_REC_M      = 4'h5;
	localparam logic [3:0]  OFF_WDT        = 4'h6;
	localparam logic [3:0]  OFF_STATUS     = 4'h7;
	localparam logic [3:0]  OFF_COUNT      = 4'h8;
	localparam logic [3:0]  OFF_PINS       = 4'h9;
	localparam logic [3:0]  OFF_ACTIVE     = 4'ha;

	// Control register bit positions
	localparam int unsigned CTRL_PROG_EN   = 0;
	localparam int unsigned CTRL_OVERRIDE  = 1;
	localparam int unsigned CTRL_REC_SRC   = 2;
	localparam int unsigned CTRL_WD_RUN    = 3;
	localparam int unsigned CTRL_WD_LONG   = 4;
	localparam int unsigned CTRL_RST_WD    = 5;
	localparam int unsigned CTRL_RST_FC    = 6;

	// Status register bit positions
	localparam int unsigned STAT_TIMEOUT   = 0;
	localparam int unsigned STAT_RECOVERY  = 1;
	localparam int unsigned STAT_RUNNING   = 2;

	// Values after reset
	localparam logic [7:0]  CTRL_RST       = 8'h00;
	localparam logic [4:0]  SEL_RST        = 5'h00;
	localparam logic [7:0]  PROG_N_RST     = 8'h61;
	localparam logic [6:0]  PROG_M_RST     = 7'h5d;
	localparam logic [7:0]  REC_N_RST      = 8'h61;
	localparam logic [6:0]  REC_M_RST      = 7'h5d;
	localparam logic [4:0]  WDT_VAL_RST    = 5'h1f;
	localparam logic [4:0]  PINS_RST       = 5'h00;

	typedef enum logic [1:0] {
		WD_IDLE,
		WD_RUN,
		WD_DONE
	} wfr_wd_state_t;

endpackage

/* design/wfr_ctl_if.sv */
`timescale 1ns/10ps
interface wfr_ctl_if;
	// Prescaler link
	logic       pre_run;
	logic       pre_long;
	logic       pre_clear;
	logic       pre_tick;
	// Frequency selection link
	logic       prog_en;
	logic       override;
	logic       recovery;
	logic       rec_src;
	logic [4:0] pin_sel;
	logic [4:0] sw_sel;
	logic [7:0] prog_n;
	logic [6:0] prog_m;
	logic [7:0] rec_n;
	logic [6:0] rec_m;
	logic [4:0] act_sel;
	logic [8:0] act_np3;
	logic [7:0] act_mp3;
	logic       act_prog;

	modport core (output pre_run, pre_long, pre_clear, input pre_tick,
		output prog_en, override, recovery, rec_src, pin_sel, sw_sel,
		output prog_n, prog_m, rec_n, rec_m,
		input act_sel, act_np3, act_mp3, act_prog);
	modport pre (input pre_run, pre_long, pre_clear, output pre_tick);
	modport frq (input prog_en, override, recovery, rec_src, pin_sel,
		input sw_sel, prog_n, prog_m, rec_n, rec_m,
		output act_sel, act_np3, act_mp3, act_prog);
endinterface

/* design/wfr_prescaler.sv */
`timescale 1ns/10ps
module wfr_prescaler
	import wfr_pkg::*;
#(
	parameter int unsigned SHORT_CYC = SHORT_TICK_CYC,
	parameter int unsigned LONG_CYC  = LONG_TICK_CYC
) (
	input  wire logic i_core_clk, // Core clock
	input  wire logic i_reset,    // Synchronous reset, active high
	wfr_ctl_if.pre    ctl         // Run, unit select and tick
);
	typedef struct packed {
		logic [TICK_CNT_W-1:0] cnt;
		logic                  tick;
	} wfr_pre_t;

	wfr_pre_t s_q;
	wfr_pre_t s_d;
	logic [TICK_CNT_W-1:0] last;

	// Unit of the watchdog: short or long tick
	assign last = ctl.pre_long ? TICK_CNT_W'(LONG_CYC - 1)
		: TICK_CNT_W'(SHORT_CYC - 1);

	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (!ctl.pre_run || ctl.pre_clear) begin
			s_d.cnt = '0;
		end else if (s_q.cnt >= last) begin
			s_d.cnt = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + TICK_CNT_W'(1);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign ctl.pre_tick = s_q.tick;
endmodule

/* design/wfr_freq_mux.sv */
`timescale 1ns/10ps
module wfr_freq_mux
	import wfr_pkg::*;
(
	wfr_ctl_if.frq ctl // Selection inputs and active frequency
);
	always_comb begin
		// Ratio and gear come from pins or software select
		ctl.act_sel = ctl.override ? ctl.sw_sel : ctl.pin_sel;
		ctl.act_prog = ctl.prog_en;
		// Divider terms of G*(N+3)/(M+3)
		ctl.act_np3 = {1'b0, ctl.prog_n} + DIV_OFFSET;
		ctl.act_mp3 = {1'b0, ctl.prog_m} + DIV_OFFSET[7:0];
		if (ctl.recovery) begin
			// Recovery frequency after a time-out
			if (ctl.rec_src) begin
				ctl.act_prog = 1'b1;
				ctl.act_np3 = {1'b0, ctl.rec_n} + DIV_OFFSET;
				ctl.act_mp3 = {1'b0, ctl.rec_m} + DIV_OFFSET[7:0];
			end else begin
				ctl.act_sel = ctl.pin_sel;
				ctl.act_prog = 1'b0;
			end
		end
	end
endmodule

/* design/wfr_watchdog.sv */
// Summary of operation
// - Ratio comes from latched pins, or software select when override set.
// - Writing recovery N or M alone starts loading the new frequency.
// - Run-enable low stops the watchdog and reloads its time-out.
// - Run-enable high: watchdog counts down after a frequency change.
// - Time-out flag reads 1 after time-out; write 1 clears, 0 ignored.
// - Five-bit time-out value, unit set by the tick select bit.
// - Span 150 ms to 4.8 s short, 2.5 s to 80 s long.
// - Count reaching zero sets the time-out flag.
// - Tick select 0 gives 150 ms units, 1 gives 2.5 s units.
// - Reset pulse on time-out only when its enable bit is set.
// - Reset pulse after frequency change only when its enable is set.
// - Programmed frequency is gear times (N+3) over (M+3).
// - Gear constant follows the active five-bit frequency select.
// - Time-out switches to recovery frequency from pins or recovery N/M.
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/10ps
module wfr_watchdog
	import wfr_pkg::*;
#(
	parameter int unsigned SHORT_CYC = SHORT_TICK_CYC,
	parameter int unsigned LONG_CYC  = LONG_TICK_CYC
) (
	input  wire logic       i_core_clk,         // Core clock, 20 MHz
	input  wire logic       i_reset,            // Synchronous reset
	input  wire logic [4:0] i_freq_select_pins, // Strap pins, taken once
	input  wire logic [3:0] i_addr,             // Register address
	input  wire logic [7:0] i_wdata,            // Register write data
	input  wire logic       i_wr,               // Write strobe
	input  wire logic       i_rd,               // Read strobe
	output logic      [7:0] o_rdata,            // Read data, next cycle
	output logic      [4:0] o_ratio_sel,        // Active ratio/gear select
	output logic      [8:0] o_div_n,            // Active N+3
	output logic      [7:0] o_div_m,            // Active M+3
	output logic            o_prog_active,      // Dividers in use
	output logic            o_freq_load,        // Load pulse to the PLL
	output logic            o_sys_reset,        // System reset pulse
	output logic            o_wdt_timeout       // Time-out flag level
);
	typedef struct packed {
		logic [7:0]    ctrl;
		logic [4:0]    sw_sel;
		logic [7:0]    prog_n;
		logic [6:0]    prog_m;
		logic [7:0]    rec_n;
		logic [6:0]    rec_m;
		logic [4:0]    wd_val;
		logic          to_flag;
		logic [5:0]    wd_cnt;
		wfr_wd_state_t wd_st;
		logic          recovery;
		logic [4:0]    pin_sel;
		logic          pins_taken;
		logic [7:0]    rdata;
		logic [4:0]    rst_cnt;
		logic          rst_out;
		logic          load_pend;
		logic          load;
		logic [4:0]    out_sel;
		logic [8:0]    out_np3;
		logic [7:0]    out_mp3;
		logic          out_prog;
	} wfr_core_t;

	wfr_core_t s_q;
	wfr_core_t s_d;
	logic      fc;
	logic      tmo;
	logic      flag_clr;
	logic      div_wr;

	wfr_ctl_if ctl ();

	wfr_prescaler #(
		.SHORT_CYC (SHORT_CYC),
		.LONG_CYC  (LONG_CYC)
	) wfr_prescaler_inst (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.ctl        (ctl)
	);

	wfr_freq_mux wfr_freq_mux_inst (
		.ctl (ctl)
	);

	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		hit = (a == off);
	endfunction

	assign ctl.pre_run   = (s_q.wd_st == WD_RUN);
	assign ctl.pre_long  = s_q.ctrl[CTRL_WD_LONG];
	assign ctl.pre_clear = fc;
	assign ctl.prog_en   = s_q.ctrl[CTRL_PROG_EN];
	assign ctl.override  = s_q.ctrl[CTRL_OVERRIDE];
	assign ctl.rec_src   = s_q.ctrl[CTRL_REC_SRC];
	assign ctl.recovery  = s_q.recovery;
	assign ctl.pin_sel   = s_q.pin_sel;
	assign ctl.sw_sel    = s_q.sw_sel;
	assign ctl.prog_n    = s_q.prog_n;
	assign ctl.prog_m    = s_q.prog_m;
	assign ctl.rec_n     = s_q.rec_n;
	assign ctl.rec_m     = s_q.rec_m;

	// A frequency change is any move of the active selection
	assign fc = (ctl.act_sel != s_q.out_sel) || (ctl.act_np3 != s_q.out_np3)
		|| (ctl.act_mp3 != s_q.out_mp3) || (ctl.act_prog != s_q.out_prog);
	assign tmo = s_q.ctrl[CTRL_WD_RUN] && (s_q.wd_st == WD_RUN) && !fc
		&& ctl.pre_tick && (s_q.wd_cnt == 6'h01);
	assign flag_clr = i_wr && hit(i_addr, OFF_STATUS) && i_wdata[STAT_TIMEOUT];
	assign div_wr = i_wr && (hit(i_addr, OFF_PROG_N) || hit(i_addr, OFF_PROG_M)
		|| hit(i_addr, OFF_REC_N) || hit(i_addr, OFF_REC_M));

	always_comb begin
		s_d = s_q;
		// Strap pins are caught once after reset is released
		if (!s_q.pins_taken) begin
			s_d.pin_sel = i_freq_select_pins;
			s_d.pins_taken = 1'b1;
		end
		if (i_wr) begin
			case (i_addr)
				OFF_CTRL:   s_d.ctrl = {1'b0, i_wdata[6:0]};
				OFF_SEL:    s_d.sw_sel = i_wdata[4:0];
				OFF_PROG_N: s_d.prog_n = i_wdata;
				OFF_PROG_M: s_d.prog_m = i_wdata[6:0];
				OFF_REC_N:  s_d.rec_n = i_wdata;
				OFF_REC_M:  s_d.rec_m = i_wdata[6:0];
				OFF_WDT:    s_d.wd_val = i_wdata[4:0];
				default:    s_d.rec_m = s_d.rec_m;
			endcase
		end
		// Each divider write loads, even if only one half changed
		s_d.load_pend = div_wr;
		s_d.load = fc || s_q.load_pend;
		s_d.out_sel = ctl.act_sel;
		s_d.out_np3 = ctl.act_np3;
		s_d.out_mp3 = ctl.act_mp3;
		s_d.out_prog = ctl.act_prog;

		// Watchdog sequencing
		if (!s_q.ctrl[CTRL_WD_RUN]) begin
			s_d.wd_st = WD_IDLE;
			s_d.wd_cnt = {1'b0, s_q.wd_val} + 6'h01;
		end else begin
			case (s_q.wd_st)
				WD_IDLE: begin
					if (fc) begin
						s_d.wd_st = WD_RUN;
						s_d.wd_cnt = {1'b0, s_q.wd_val} + 6'h01;
					end
				end
				WD_RUN: begin
					if (fc) begin
						s_d.wd_cnt = {1'b0, s_q.wd_val} + 6'h01;
					end else if (tmo) begin
						s_d.wd_cnt = 6'h00;
						s_d.wd_st = WD_DONE;
					end else if (ctl.pre_tick) begin
						s_d.wd_cnt = s_q.wd_cnt - 6'h01;
					end
				end
				WD_DONE: s_d.wd_cnt = 6'h00;
				default: s_d.wd_st = WD_IDLE;
			endcase
		end

		// Set wins over a clear in the same cycle
		s_d.to_flag = tmo || (s_q.to_flag && !flag_clr);
		// Recovery holds until software acknowledges the time-out
		s_d.recovery = tmo || (s_q.recovery && !flag_clr);

		// Reset pulse generation
		if ((tmo && s_q.ctrl[CTRL_RST_WD]) || (fc && s_q.ctrl[CTRL_RST_FC])) begin
			s_d.rst_cnt = RST_PULSE_CYC;
		end else if (s_q.rst_cnt != 5'h00) begin
			s_d.rst_cnt = s_q.rst_cnt - 5'h01;
		end
		s_d.rst_out = (s_d.rst_cnt != 5'h00);

		// Read data stand only in the cycle after the strobe
		s_d.rdata = 8'h00;
		if (i_rd) begin
			case (i_addr)
				OFF_CTRL:   s_d.rdata = s_q.ctrl;
				OFF_SEL:    s_d.rdata = {3'h0, s_q.sw_sel};
				OFF_PROG_N: s_d.rdata = s_q.prog_n;
				OFF_PROG_M: s_d.rdata = {1'b0, s_q.prog_m};
				OFF_REC_N:  s_d.rdata = s_q.rec_n;
				OFF_REC_M:  s_d.rdata = {1'b0, s_q.rec_m};
				OFF_WDT:    s_d.rdata = {3'h0, s_q.wd_val};
				OFF_STATUS: s_d.rdata = {5'h00, (s_q.wd_st == WD_RUN),
					s_q.recovery, s_q.to_flag};
				OFF_COUNT:  s_d.rdata = {2'h0, s_q.wd_cnt};
				OFF_PINS:   s_d.rdata = {3'h0, s_q.pin_sel};
				OFF_ACTIVE: s_d.rdata = {2'h0, s_q.out_prog, s_q.out_sel};
				default:    s_d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			s_q <= '{ctrl: CTRL_RST, sw_sel: SEL_RST, prog_n: PROG_N_RST,
				prog_m: PROG_M_RST, rec_n: REC_N_RST, rec_m: REC_M_RST,
				wd_val: WDT_VAL_RST, to_flag: 1'b0,
				wd_cnt: {1'b0, WDT_VAL_RST} + 6'h01, wd_st: WD_IDLE,
				recovery: 1'b0, pin_sel: PINS_RST, pins_taken: 1'b0,
				rdata: 8'h00, rst_cnt: 5'h00, rst_out: 1'b0,
				load_pend: 1'b0, load: 1'b0, out_sel: PINS_RST,
				out_np3: {1'b0, PROG_N_RST} + DIV_OFFSET,
				out_mp3: {1'b0, PROG_M_RST} + DIV_OFFSET[7:0],
				out_prog: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign o_rdata       = s_q.rdata;
	assign o_ratio_sel   = s_q.out_sel;
	assign o_div_n       = s_q.out_np3;
	assign o_div_m       = s_q.out_mp3;
	assign o_prog_active = s_q.out_prog;
	assign o_freq_load   = s_q.load;
	assign o_sys_reset   = s_q.rst_out;
	assign o_wdt_timeout = s_q.to_flag;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	a_flag_write_one: assert property (
		s_q.to_flag && flag_clr && !tmo |=> !o_wdt_timeout)
		else $error("flag not cleared by one");
	a_flag_write_zero: assert property (
		s_q.to_flag && i_wr && hit(i_addr, OFF_STATUS)
		&& !i_wdata[STAT_TIMEOUT] |=> o_wdt_timeout)
		else $error("flag lost on zero write");
	a_flag_needs_timeout: assert property (
		!s_q.to_flag && !tmo |=> !o_wdt_timeout)
		else $error("flag set without time-out");
	a_stop_and_reload: assert property (
		!s_q.ctrl[CTRL_WD_RUN]
		|=> s_q.wd_st == WD_IDLE
		&& s_q.wd_cnt == {1'b0, $past(s_q.wd_val)} + 6'h01)
		else $error("watchdog not reloaded");
	a_start_on_change: assert property (
		s_q.ctrl[CTRL_WD_RUN] && s_q.wd_st == WD_IDLE && fc
		|=> s_q.wd_st == WD_RUN)
		else $error("watchdog did not start");
	a_count_step_down: assert property (
		s_q.ctrl[CTRL_WD_RUN] && s_q.wd_st == WD_RUN && !fc
		&& ctl.pre_tick && s_q.wd_cnt > 6'h01
		|=> s_q.wd_cnt == $past(s_q.wd_cnt) - 6'h01)
		else $error("count did not step");
	a_zero_sets_flag: assert property (
		tmo |=> o_wdt_timeout && s_q.wd_cnt == 6'h00 && s_q.recovery)
		else $error("time-out not flagged");
	a_wd_reset_pulse: assert property (
		tmo && s_q.ctrl[CTRL_RST_WD] |=> o_sys_reset [*8])
		else $error("no reset after time-out");
	a_fc_reset_pulse: assert property (
		fc && s_q.ctrl[CTRL_RST_FC] |=> o_sys_reset)
		else $error("no reset on change");
	a_no_reset_pulse: assert property (
		!o_sys_reset && !s_q.ctrl[CTRL_RST_WD]
		&& !s_q.ctrl[CTRL_RST_FC] |=> !o_sys_reset)
		else $error("reset pulse while disabled");
	a_ratio_from_pins: assert property (
		!s_q.recovery && !s_q.ctrl[CTRL_OVERRIDE]
		|=> o_ratio_sel == $past(s_q.pin_sel))
		else $error("ratio not from pins");
	a_ratio_from_sel: assert property (
		!s_q.recovery && s_q.ctrl[CTRL_OVERRIDE]
		|=> o_ratio_sel == $past(s_q.sw_sel))
		else $error("ratio not from select");
	a_prog_from_ctrl: assert property (
		!s_q.recovery
		|=> o_prog_active == $past(s_q.ctrl[CTRL_PROG_EN]))
		else $error("programmed mode not followed");
	a_divider_terms: assert property (
		!s_q.recovery
		|=> o_div_n == {1'b0, $past(s_q.prog_n)} + DIV_OFFSET
		&& o_div_m == {1'b0, $past(s_q.prog_m)} + DIV_OFFSET[7:0])
		else $error("divider terms wrong");
	a_recovery_pins: assert property (
		s_q.recovery && !s_q.ctrl[CTRL_REC_SRC]
		|=> o_ratio_sel == $past(s_q.pin_sel) && !o_prog_active)
		else $error("recovery not from pins");
	a_recovery_dividers: assert property (
		s_q.recovery && s_q.ctrl[CTRL_REC_SRC]
		|=> o_prog_active
		&& o_div_n == {1'b0, $past(s_q.rec_n)} + DIV_OFFSET
		&& o_div_m == {1'b0, $past(s_q.rec_m)} + DIV_OFFSET[7:0])
		else $error("recovery dividers wrong");
	a_load_on_change: assert property (
		fc |=> o_freq_load)
		else $error("no load on frequency change");
	a_recovery_load: assert property (
		div_wr && hit(i_addr, OFF_REC_N) |-> ##2 o_freq_load)
		else $error("recovery write not loaded");
	a_rec_m_load: assert property (
		div_wr && hit(i_addr, OFF_REC_M) |-> ##2 o_freq_load)
		else $error("recovery M write not loaded");
	a_status_read: assert property (
		i_rd && hit(i_addr, OFF_STATUS)
		|=> o_rdata[STAT_TIMEOUT] == $past(s_q.to_flag))
		else $error("flag read wrong");

	c_timeout: cover property (tmo ##1 o_wdt_timeout);
	c_recovery_dividers: cover property (s_q.recovery
		&& s_q.ctrl[CTRL_REC_SRC] && o_prog_active);
	c_recovery_pins: cover property (s_q.recovery
		&& !s_q.ctrl[CTRL_REC_SRC]);
	c_flag_cleared: cover property (o_wdt_timeout ##1 !o_wdt_timeout);
	c_reset_pulse: cover property (!o_sys_reset ##1 o_sys_reset);
endmodule

/* tb/wfr_host_model.sv */
`timescale 1ns/10ps
module wfr_host_model
	import wfr_pkg::*;
(
	input  wire logic       i_core_clk, // Core clock
	input  wire logic [7:0] i_rdata,    // Read data from the device
	output logic      [3:0] o_addr,     // Register address
	output logic      [7:0] o_wdata,    // Write data
	output logic            o_wr,       // Write strobe
	output logic            o_rd        // Read strobe
);
	initial begin
		o_addr = 4'h0;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		o_wr <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_core_clk);
		o_wr <= 1'b0;
		// Stale data must not look like a valid write
		o_wdata <= ~d;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge i_core_clk);
		o_rd <= 1'b1;
		o_addr <= a;
		@(posedge i_core_clk);
		o_rd <= 1'b0;
		#1 d = i_rdata;
	endtask

	// Both recovery dividers in adjacent cycles, no frequency in between
	task automatic wr_rec(input logic [7:0] n, input logic [6:0] m);
		if ({1'b0, n} <= {2'b00, m})
			$display("host: recovery ratio not above one");
		@(posedge i_core_clk);
		o_wr <= 1'b1;
		o_addr <= OFF_REC_N;
		o_wdata <= n;
		@(posedge i_core_clk);
		o_addr <= OFF_REC_M;
		o_wdata <= {1'b0, m};
		@(posedge i_core_clk);
		o_wr <= 1'b0;
	endtask
endmodule

/* tb/wfr_watchdog_tb_top.sv */
`timescale 1ns/10ps
`define CHK(a, e) begin \
	cmp_count++; \
	if ((a) !== (e)) begin \
		err_count++; \
		$display("wrong value at %0t: got %h expected %h", $time, a, e); \
	end \
end
module wfr_watchdog_tb_top;
	import wfr_pkg::*;
	logic       clk;
	logic       rst;
	logic [4:0] pins;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic [4:0] ratio;
	logic [8:0] div_n;
	logic [7:0] div_m;
	logic       prog;
	logic       load;
	logic       sys_rst;
	logic       tmo;
	int         rst_edges;
	int         err_count;
	int         cmp_count;

	wfr_watchdog #(.SHORT_CYC(10), .LONG_CYC(40)) wfr_watchdog_inst (
		.i_core_clk(clk), .i_reset(rst), .i_freq_select_pins(pins),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .o_ratio_sel(ratio), .o_div_n(div_n),
		.o_div_m(div_m), .o_prog_active(prog), .o_freq_load(load),
		.o_sys_reset(sys_rst), .o_wdt_timeout(tmo));

	wfr_host_model wfr_host_model_inst (
		.i_core_clk(clk), .i_rdata(rdata), .o_addr(addr),
		.o_wdata(wdata), .o_wr(wr), .o_rd(rd));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Counts clock edges with the reset pulse high
	always @(posedge clk)
		if (sys_rst === 1'b1)
			rst_edges <= rst_edges + 1;

	task automatic wrap_up;
		$display("comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic w(input logic [3:0] a, input logic [7:0] d);
		wfr_host_model_inst.wr(a, d);
	endtask

	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		wfr_host_model_inst.rd(a, d);
		`CHK(d, e)
	endtask

	// Sel 0 waits for the flag, 1 for a reset pulse, 2 for a load pulse
	task automatic wait_bit(input int sel, input int lim, output int n);
		n = 0;
		// Step off the edge that may launch the awaited output
		#1;
		while (!((sel == 0 && tmo === 1'b1) || (sel == 1 && sys_rst === 1'b1)
			|| (sel == 2 && load === 1'b1))) begin
			@(posedge clk);
			#1;
			n++;
			if (n > lim) begin
				$display("wait limit reached at %0t", $time);
				err_count++;
				wrap_up();
			end
		end
	endtask

	task automatic expect_timeout(input int e);
		int n;
		wait_bit(0, e + 40, n);
		`CHK(n >= e - 1 && n <= e + 4, 1'b1)
	endtask

	task automatic done_test(input string name);
		$display("test %s done", name);
	endtask

	initial begin
		int n;
		int r;
		err_count = 0;
		cmp_count = 0;
		rst = 1'b1;
		pins = 5'h05;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		idle(4);
		`CHK(ratio, 5'h05)
		`CHK(div_n, {1'b0, PROG_N_RST} + DIV_OFFSET)
		`CHK(div_m, {1'b0, PROG_M_RST} + DIV_OFFSET[7:0])
		rchk(OFF_CTRL, 8'h00);
		rchk(OFF_REC_N, REC_N_RST);
		rchk(OFF_WDT, {3'h0, WDT_VAL_RST});
		rchk(4'hb, 8'h00);
		w(OFF_PINS, 8'h00);
		rchk(OFF_PINS, 8'h05);
		done_test("reset");

		w(OFF_SEL, 8'h0a);
		idle(3);
		`CHK(ratio, 5'h05)
		w(OFF_CTRL, 8'h02);
		idle(3);
		`CHK(ratio, 5'h0a)
		w(OFF_PROG_N, 8'h80);
		w(OFF_PROG_M, 8'h2d);
		w(OFF_CTRL, 8'h03);
		idle(3);
		`CHK({prog, div_n, div_m}, {1'b1, 9'h083, 8'h30})
		w(OFF_CTRL, 8'h02);
		done_test("select");

		w(OFF_WDT, 8'h01);
		w(OFF_CTRL, 8'h2a);
		idle(30);
		`CHK(tmo, 1'b0)
		w(OFF_SEL, 8'h0c);
		rchk(OFF_STATUS, 8'h04);
		expect_timeout(20);
		`CHK(sys_rst, 1'b1)
		idle(4);
		`CHK({ratio, prog}, {5'h05, 1'b0})
		rchk(OFF_COUNT, 8'h00);
		rchk(OFF_STATUS, 8'h03);
		rchk(OFF_ACTIVE, 8'h05);
		w(OFF_STATUS, 8'h00);
		idle(2);
		`CHK(tmo, 1'b1)
		w(OFF_STATUS, 8'h01);
		idle(2);
		`CHK(tmo, 1'b0)
		done_test("short time-out");

		w(OFF_CTRL, 8'h02);
		idle(2);
		rchk(OFF_COUNT, 8'h02);
		w(OFF_WDT, 8'hff);
		rchk(OFF_WDT, 8'h1f);
		rchk(OFF_COUNT, 8'h20);
		done_test("stop and reload");

		wfr_host_model_inst.wr_rec(8'h50, 7'h2d);
		w(OFF_WDT, 8'h00);
		w(OFF_CTRL, 8'h1e);
		idle(20);
		r = rst_edges;
		w(OFF_SEL, 8'h0d);
		expect_timeout(40);
		idle(4);
		`CHK(rst_edges, r)
		`CHK({prog, div_n, div_m}, {1'b1, 9'h053, 8'h30})
		w(OFF_REC_N, 8'h60);
		wait_bit(2, 6, n);
		idle(3);
		`CHK(div_n, 9'h063)
		done_test("long time-out");

		w(OFF_CTRL, 8'h5e);
		idle(20);
		w(OFF_REC_M, 8'h2e);
		wait_bit(1, 8, n);
		idle(3);
		`CHK(div_m, 8'h31)
		done_test("reset on change");
		wrap_up();
	end
endmodule
